/* File: logic/sdci_pkg.sv */
// Purpose: shared constants for the synchronous dram command interface
// Assumes: single clock ref_clk at 40 MHz, asynchronous active-low reset
// Notes: array geometry, command codes and cke states live here
package sdci_pkg;
  localparam int unsigned sdci_banks = 4;
  localparam int unsigned sdci_bank_bits = 2;
  localparam int unsigned sdci_addr_bits = 14;
  localparam int unsigned sdci_rows_x16 = 8192;
  localparam int unsigned sdci_cols_x16 = 1024;
  localparam int unsigned sdci_rows_x32 = 8192;
  localparam int unsigned sdci_cols_x32 = 512;
  localparam int unsigned sdci_rows_rps = 16384;
  localparam int unsigned sdci_cols_rps = 256;
  localparam longint unsigned sdci_bank_size_bits = 134217728;
  localparam longint unsigned sdci_device_bits = 536870912;
  localparam int unsigned sdci_mask_latency = 2;
  localparam int unsigned sdci_prech_all_bit = 10;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] sdci_cmd_nop = 4'h7;
  localparam logic [3:0] sdci_cmd_active = 4'h3;
  localparam logic [3:0] sdci_cmd_read = 4'h5;
  localparam logic [3:0] sdci_cmd_write = 4'h4;
  localparam logic [3:0] sdci_cmd_burst_term = 4'h6;
  localparam logic [3:0] sdci_cmd_precharge = 4'h2;
  localparam logic [3:0] sdci_cmd_refresh = 4'h1;
  localparam logic [3:0] sdci_cmd_load_mode = 4'h0;
  localparam logic [3:0] sdci_cmd_deselect = 4'h8;
  typedef enum logic [1:0] {
    sdci_org_x16,
    sdci_org_x32,
    sdci_org_x32_rps
  } sdci_org_type;
  typedef enum {
    sdci_pwr_run,
    sdci_pwr_precharge_down,
    sdci_pwr_active_down,
    sdci_pwr_self_refresh,
    sdci_pwr_suspend
  } sdci_pwr_type;
  // number of columns for an organisation
  function automatic int unsigned sdci_cols(input sdci_org_type org);
    case (org)
      sdci_org_x16: sdci_cols = sdci_cols_x16;
      sdci_org_x32: sdci_cols = sdci_cols_x32;
      default: sdci_cols = sdci_cols_rps;
    endcase
  endfunction : sdci_cols
  // number of rows for an organisation
  function automatic int unsigned sdci_rows(input sdci_org_type org);
    case (org)
      sdci_org_x16: sdci_rows = sdci_rows_x16;
      sdci_org_x32: sdci_rows = sdci_rows_x32;
      default: sdci_rows = sdci_rows_rps;
    endcase
  endfunction : sdci_rows
endpackage : sdci_pkg

/* File: logic/sdci_if.sv */
// Purpose: pin bundle between controller and dram device
// Assumes: controller drives all command pins; data is two-way
// Notes: the wire level of the data bus is resolved by the bench
`timescale 1ns/1ps
`default_nettype none
interface sdci_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bank;
  logic [13:0] addr;
  logic [3:0] byte_mask;
  logic [31:0] dq_ctl_out;
  logic dq_ctl_oe;
  logic [31:0] dq_dev_out;
  logic [3:0] dq_dev_oe;
  logic [31:0] dq_ctl_in;
  logic [31:0] dq_dev_in;
  modport ctl (
    output cke, cs_n, ras_n, cas_n, we_n, bank, addr, byte_mask,
    output dq_ctl_out, dq_ctl_oe,
    input dq_ctl_in
  );
  modport dev (
    input cke, cs_n, ras_n, cas_n, we_n, bank, addr, byte_mask,
    output dq_dev_out, dq_dev_oe,
    input dq_dev_in
  );
endinterface : sdci_if
`default_nettype wire

/* File: logic/sdci_bank.sv */
// Purpose: one bank's row state and precharge tracking
// Assumes: commands arrive already decoded and qualified
// Notes: four copies operate concurrently inside the device end
`timescale 1ns/1ps
`default_nettype none
module sdci_bank #(
  parameter int unsigned row_bits = 14
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic activate,
  input wire logic precharge,
  input wire logic [row_bits-1:0] row,
  output logic open,
  output logic [row_bits-1:0] open_row
);
  // row opens on activate, closes on precharge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      open <= 1'b0;
      open_row <= '0;
    end else if (activate) begin
      open <= 1'b1;
      open_row <= row;
    end else if (precharge) begin
      open <= 1'b0;
    end
  end
endmodule : sdci_bank
`default_nettype wire

/* File: logic/sdci_device.sv */
// Purpose: dram device end: command decode, banks, burst, masks, cke
// Assumes: pins are synchronous to ref_clk, driven by the controller
// Notes: data array is a small window; addresses wrap into it
`timescale 1ns/1ps
`default_nettype none
module sdci_device #(
  parameter sdci_pkg::sdci_org_type org = sdci_pkg::sdci_org_x32,
  parameter int unsigned burst_len = 4,
  parameter int unsigned mem_words = 256
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sdci_if.dev pins,
  output logic [3:0] bank_open,
  output logic powered_down,
  output logic suspended
);
  localparam int unsigned mw = $clog2(mem_words);
  localparam int unsigned col_bits = $clog2(sdci_pkg::sdci_cols(org));
  localparam int unsigned row_bits = $clog2(sdci_pkg::sdci_rows(org));
  localparam int unsigned blw = $clog2(burst_len) + 1;
  // data width follows the option; every option holds the same bits per
  // bank, so a wider word comes with fewer columns or rows
  localparam int unsigned dq_width =
    (org == sdci_pkg::sdci_org_x16) ? 16 : 32;
  localparam longint unsigned bank_cap = longint'(sdci_pkg::sdci_rows(org)) *
    longint'(sdci_pkg::sdci_cols(org)) * longint'(dq_width);
  logic [31:0] mem [mem_words];
  logic [3:0] cmd;
  logic live;
  logic [3:0] act_bank;
  logic [3:0] pre_bank;
  logic [3:0] lane_mask;
  logic in_burst;
  logic burst_write;
  logic [1:0] burst_bank;
  logic [col_bits-1:0] col;
  logic [blw-1:0] left;
  logic [row_bits-1:0] bank_row [4];
  logic [1:0][3:0] mask_pipe;
  logic [1:0] rd_pipe;
  logic [31:0] rd_data;
  logic [mw-1:0] rd_idx;
  logic [mw-1:0] wr_idx;
  logic col_cmd;
  logic beat;
  logic [31:0] rd_stage;
  sdci_pkg::sdci_pwr_type pwr;

  // true when the sampled strobes, select included, carry a command code
  function automatic logic strobes_are(input logic [3:0] code);
    strobes_are = ({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} == code);
  endfunction : strobes_are

  // x16 maps lower/upper masks to two lanes, x32 to four lanes
  assign lane_mask = (org == sdci_pkg::sdci_org_x16) ?
    {2'h3, pins.byte_mask[1:0]} : pins.byte_mask;
  // decoder only runs with clock enabled, receivers on, select low
  assign live = pins.cke && (pwr == sdci_pkg::sdci_pwr_run);
  assign cmd = (live && !pins.cs_n) ?
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} :
    sdci_pkg::sdci_cmd_nop;
  assign col_cmd = (cmd == sdci_pkg::sdci_cmd_read) ||
    (cmd == sdci_pkg::sdci_cmd_write);
  // a burst beat needs the clock; terminate or precharge cuts it off
  assign beat = live && in_burst && !col_cmd &&
    (cmd != sdci_pkg::sdci_cmd_burst_term) && !pre_bank[burst_bank];
  assign powered_down = (pwr != sdci_pkg::sdci_pwr_run) &&
    (pwr != sdci_pkg::sdci_pwr_suspend);
  assign suspended = (pwr == sdci_pkg::sdci_pwr_suspend);

  // per-bank activate and precharge strobes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      act_bank[b] = (cmd == sdci_pkg::sdci_cmd_active) &&
        (pins.bank == 2'(b));
      pre_bank[b] = (cmd == sdci_pkg::sdci_cmd_precharge) &&
        (pins.addr[sdci_pkg::sdci_prech_all_bit] ||
         pins.bank == 2'(b));
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_bank
    sdci_bank #(.row_bits(row_bits)) u_bank (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .activate(act_bank[g]),
      .precharge(pre_bank[g]),
      .row(pins.addr[row_bits-1:0]),
      .open(bank_open[g]),
      .open_row(bank_row[g])
    );
  end

  // cke low picks the low-power state from current activity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr <= sdci_pkg::sdci_pwr_run;
    end else begin
      case (pwr)
        sdci_pkg::sdci_pwr_run: begin
          if (!pins.cke) begin
            if (in_burst)
              pwr <= sdci_pkg::sdci_pwr_suspend;
            else if (bank_open != 4'h0)
              pwr <= sdci_pkg::sdci_pwr_active_down;
            else if (strobes_are(sdci_pkg::sdci_cmd_refresh))
              pwr <= sdci_pkg::sdci_pwr_self_refresh;
            else
              pwr <= sdci_pkg::sdci_pwr_precharge_down;
          end
        end
        sdci_pkg::sdci_pwr_suspend: begin
          if (pins.cke) pwr <= sdci_pkg::sdci_pwr_run;
        end
        default: begin
          // only cke is watched; other inputs are ignored
          if (pins.cke) pwr <= sdci_pkg::sdci_pwr_run;
        end
      endcase
    end
  end

  // burst column counter; a new column command restarts it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_burst <= 1'b0;
      col <= '0;
      left <= '0;
    end else if (col_cmd) begin
      in_burst <= (burst_len > 1);
      col <= pins.addr[col_bits-1:0] + 1'b1;
      left <= blw'(burst_len - 1);
    end else if (live && in_burst) begin
      col <= col + 1'b1;
      left <= left - 1'b1;
      if (left == blw'(1)) in_burst <= 1'b0;
      // terminate or a precharge of the burst bank ends the burst early
      if (cmd == sdci_pkg::sdci_cmd_burst_term ||
          pre_bank[burst_bank]) in_burst <= 1'b0;
    end
  end

  // kind and bank of a burst are fixed by its column command
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_write <= 1'b0;
      burst_bank <= 2'h0;
    end else if (col_cmd) begin
      burst_write <= (cmd == sdci_pkg::sdci_cmd_write);
      burst_bank <= pins.bank;
    end
  end

  // address into the storage window for the current beat
  // only the low bits index the window, so distant locations alias
  always_comb begin
    logic [31:0] wide;
    wide = '0;
    if (col_cmd) begin
      wide = 32'({pins.bank, bank_row[pins.bank][3:0],
                  col_bits'(pins.addr[col_bits-1:0])});
    end else begin
      wide = 32'({burst_bank, bank_row[burst_bank][3:0], col});
    end
    wr_idx = wide[mw-1:0];
    rd_idx = wide[mw-1:0];
  end

  // masked write lanes keep their stored byte
  always_ff @(posedge ref_clk) begin
    if ((cmd == sdci_pkg::sdci_cmd_write) || (beat && burst_write)) begin
      for (int l = 0; l < 4; l++) begin
        if (!lane_mask[l])
          mem[wr_idx][8*l +: 8] <= pins.dq_dev_in[8*l +: 8];
      end
    end
  end

  // read enable and mask travel two stages to the pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pipe <= 2'h0;
      mask_pipe <= '0;
    end else if (pins.cke) begin
      rd_pipe[0] <= (cmd == sdci_pkg::sdci_cmd_read) ||
        (beat && !burst_write);
      rd_pipe[1] <= rd_pipe[0];
      mask_pipe[0] <= lane_mask;
      mask_pipe[1] <= mask_pipe[0];
    end
  end

  // read data takes the same two stages so it lines up with its enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_stage <= 32'h0;
      rd_data <= 32'h0;
    end else if (pins.cke) begin
      rd_stage <= mem[rd_idx];
      rd_data <= rd_stage;
    end
  end

  assign pins.dq_dev_out = rd_data;
  assign pins.dq_dev_oe = {4{rd_pipe[1]}} & ~mask_pipe[1];
endmodule : sdci_device
`default_nettype wire

/* File: logic/sdci_controller.sv */
// Purpose: controller end: drives commands from a user request port
// Assumes: user holds each request until accepted by req_ready
// Notes: issues one command per accepted request; no sequencing
`timescale 1ns/1ps
`default_nettype none
module sdci_controller (
  input wire logic ref_clk,
  input wire logic rst_n,
  sdci_if.ctl pins,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic [13:0] req_addr,
  input wire logic [3:0] req_mask,
  input wire logic [31:0] req_wdata,
  input wire logic req_cke,
  output logic [31:0] rd_data
);
  logic [31:0] dq_s1;
  // one command per cycle, all strobes from one register set
  assign req_ready = 1'b1;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.cke <= 1'b1;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
        sdci_pkg::sdci_cmd_deselect;
      pins.bank <= 2'h0;
      pins.addr <= 14'h0;
      pins.byte_mask <= 4'h0;
      pins.dq_ctl_out <= 32'h0;
      pins.dq_ctl_oe <= 1'b0;
    end else begin
      pins.cke <= req_cke;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= req_valid ?
        req_cmd : sdci_pkg::sdci_cmd_deselect;
      pins.bank <= req_bank;
      pins.addr <= req_addr;
      pins.byte_mask <= req_mask;
      pins.dq_ctl_out <= req_wdata;
      pins.dq_ctl_oe <= req_valid && (req_cmd == sdci_pkg::sdci_cmd_write);
    end
  end
  // read data passes two flip-flops from the bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1 <= 32'h0;
      rd_data <= 32'h0;
    end else begin
      dq_s1 <= pins.dq_ctl_in;
      rd_data <= dq_s1;
    end
  end
endmodule : sdci_controller
`default_nettype wire

/* File: dv/sdci_properties.sv */
// Purpose: timing checks on the dram pin bundle
// Assumes: x32 organisation, burst of four
// Notes: sits beside the interface, sees pins only
`timescale 1ns/1ps
`default_nettype none
module sdci_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [3:0] byte_mask,
  input wire logic [31:0] dq_dev_out,
  input wire logic [3:0] dq_dev_oe,
  input wire logic dq_ctl_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // unmasked read, idle and quiet cycles as seen on the pins
  sequence rd_s;
    cke && !cs_n && {ras_n, cas_n, we_n} == 3'h5 && byte_mask == 4'h0;
  endsequence
  sequence idle_s;
    cke && cs_n && byte_mask == 4'h0;
  endsequence
  sequence quiet_s;
    cke && cs_n && byte_mask == 4'h0 && dq_dev_oe == 4'h0;
  endsequence
  // read and mask timing
  a_read_latency: assert property (
    rd_s ##1 cke [*2] |-> dq_dev_oe == 4'hF)
    else $error("read data lanes late");
  a_mask_hiz: assert property (
    cke [*3] |-> (dq_dev_oe & $past(byte_mask, 2)) == 4'h0)
    else $error("masked lane driven");
  a_burst_len: assert property (
    rd_s ##1 idle_s [*6] |-> dq_dev_oe == 4'h0 && $past(dq_dev_oe) == 4'hF)
    else $error("burst length wrong");
  // deselect and clock enable
  a_desel_nop: assert property (
    quiet_s [*2] ##1 (cke && cs_n) |-> dq_dev_oe == 4'h0)
    else $error("deselect started a transfer");
  a_cke_freeze: assert property (
    !cke |=> $stable(dq_dev_oe) && $stable(dq_dev_out))
    else $error("outputs moved with clock stopped");
  a_pd_ignore: assert property (
    quiet_s [*3] ##1 !cke ##1 (!cke && !cs_n && {ras_n, cas_n, we_n} == 3'h5)
    ##1 !cke ##1 (cke && cs_n) [*3] |-> dq_dev_oe == 4'h0)
    else $error("read taken in power-down");
  // data bus ownership
  a_write_data: assert property (
    cke && !cs_n && {ras_n, cas_n, we_n} == 3'h4 |-> dq_ctl_oe)
    else $error("write without data");
  a_one_driver: assert property (
    dq_dev_oe != 4'h0 |-> !dq_ctl_oe)
    else $error("both ends drive data");
endmodule : sdci_properties
`default_nettype wire

/* File: dv/sdram_core_interface_tb_top.sv */
// Purpose: drives both ends of the dram pin bundle
// Assumes: x32 device, burst of four, one request per cycle
// Notes: pins lag each request by one edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module sdram_core_interface_tb_top;
  localparam logic [3:0] c_act = sdci_pkg::sdci_cmd_active;
  localparam logic [3:0] c_rd = sdci_pkg::sdci_cmd_read;
  localparam logic [3:0] c_wr = sdci_pkg::sdci_cmd_write;
  localparam logic [3:0] c_pre = sdci_pkg::sdci_cmd_precharge;
  localparam logic [3:0] c_bst = sdci_pkg::sdci_cmd_burst_term;
  localparam logic [3:0] c_ds = sdci_pkg::sdci_cmd_deselect;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b1;
  logic [3:0] req_cmd = c_ds;
  logic [1:0] req_bank = 2'h0;
  logic [13:0] req_addr = 14'h0;
  logic [3:0] req_mask = 4'h0;
  logic [31:0] req_wdata = 32'h0;
  logic req_cke = 1'b1;
  logic [3:0] bank_open;
  logic powered_down;
  logic suspended;
  logic ready;
  logic [31:0] ctl_rd;
  logic [31:0] bus_w;
  logic [31:0] bus_q = 32'h0;
  logic [31:0] got [8];
  logic [3:0] oe0;
  int checked = 0;
  int n_mismatch = 0;
  int nbeat;
  sdci_if sdci_if_inst();
  sdci_device sdci_device_inst(.ref_clk(ref_clk), .rst_n(rst_n),
    .pins(sdci_if_inst), .bank_open(bank_open),
    .powered_down(powered_down), .suspended(suspended));
  sdci_controller sdci_controller_inst(.ref_clk(ref_clk), .rst_n(rst_n),
    .pins(sdci_if_inst), .req_valid(req_valid), .req_ready(ready),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_mask(req_mask), .req_wdata(req_wdata), .req_cke(req_cke),
    .rd_data(ctl_rd));
  sdci_properties sdci_properties_inst(.ref_clk(ref_clk), .rst_n(rst_n),
    .cke(sdci_if_inst.cke), .cs_n(sdci_if_inst.cs_n),
    .ras_n(sdci_if_inst.ras_n), .cas_n(sdci_if_inst.cas_n),
    .we_n(sdci_if_inst.we_n), .byte_mask(sdci_if_inst.byte_mask),
    .dq_dev_out(sdci_if_inst.dq_dev_out), .dq_dev_oe(sdci_if_inst.dq_dev_oe),
    .dq_ctl_oe(sdci_if_inst.dq_ctl_oe));
  // clock
  always #12.5 ref_clk = ~ref_clk;
  // data wire per lane; a lane nobody drives flips every cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bus_w[8*i +: 8] = sdci_if_inst.dq_dev_oe[i] ?
        sdci_if_inst.dq_dev_out[8*i +: 8] : sdci_if_inst.dq_ctl_oe ?
        sdci_if_inst.dq_ctl_out[8*i +: 8] : ~bus_q[8*i +: 8];
    end
  end
  // last wire level
  always @(posedge ref_clk) bus_q <= bus_w;
  assign sdci_if_inst.dq_ctl_in = bus_w;
  assign sdci_if_inst.dq_dev_in = bus_w;
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
    input logic [13:0] a, input logic [3:0] m, input logic [31:0] d,
    input logic k);
    @(posedge ref_clk);
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_mask <= m;
    req_wdata <= d;
    req_cke <= k;
  endtask : issue
  task automatic idle(input int n, input logic k);
    repeat (n) issue(c_ds, 2'h0, 14'h0, 4'h0, 32'h0, k);
  endtask : idle
  // read column 0 and collect the beats off the wire
  task automatic rd_run(input logic [1:0] b, input logic [3:0] m);
    nbeat = 0;
    issue(c_rd, b, 14'h0, m, 32'h0, 1'b1);
    for (int i = 1; i <= 8; i++) begin
      idle(1, 1'b1);
      #1;
      if (sdci_if_inst.dq_dev_oe !== 4'h0) begin
        if (nbeat == 0) oe0 = sdci_if_inst.dq_dev_oe;
        got[nbeat] = bus_w;
        nbeat++;
      end
      // controller read data trails the wire by two flops
      if (i >= 5) `CHK(ctl_rd, got[i - 5])
    end
  endtask : rd_run
  task automatic t_banks();
    for (int i = 0; i < 4; i++) issue(c_act, 2'(i), 14'h10, 4'h0, 32'h0, 1'b1);
    idle(3, 1'b1);
    #1 `CHK(bank_open, 4'hF)
    `CHK(ready, 1'b1)
    issue(c_pre, 2'h2, 14'h0000, 4'h0, 32'h0, 1'b1);
    idle(3, 1'b1);
    #1 `CHK(bank_open, 4'hB)
    issue(c_pre, 2'h0, 14'h0400, 4'h0, 32'h0, 1'b1);
    idle(3, 1'b1);
    #1 `CHK(bank_open, 4'h0)
  endtask : t_banks
  task automatic t_burst();
    issue(c_act, 2'h1, 14'h5, 4'h0, 32'h0, 1'b1);
    idle(2, 1'b1);
    for (int i = 0; i < 4; i++)
      issue(c_wr, 2'h1, 14'(i), 4'h0, 32'h11111111 * (i + 1), 1'b1);
    issue(c_bst, 2'h1, 14'h0, 4'h0, 32'h0, 1'b1);
    issue(c_wr, 2'h1, 14'h1, 4'hA, 32'hFFFFFFFF, 1'b1);
    issue(c_bst, 2'h1, 14'h0, 4'h0, 32'h0, 1'b1);
    idle(2, 1'b1);
    rd_run(2'h1, 4'h0);
    `CHK(nbeat, 4)
    `CHK(got[0], 32'h11111111)
    `CHK(got[1], 32'h22FF22FF)
    `CHK(got[2], 32'h33333333)
    `CHK(got[3], 32'h44444444)
    rd_run(2'h1, 4'h5);
    `CHK(oe0, 4'hA)
  endtask : t_burst
  task automatic t_power();
    issue(c_pre, 2'h0, 14'h0400, 4'h0, 32'h0, 1'b1);
    idle(3, 1'b1);
    idle(1, 1'b0);
    issue(c_rd, 2'h1, 14'h0, 4'h0, 32'h0, 1'b0);
    idle(1, 1'b0);
    #1 `CHK(powered_down, 1'b1)
    repeat (4) begin
      idle(1, 1'b1);
      #1 `CHK(sdci_if_inst.dq_dev_oe, 4'h0)
    end
    `CHK(powered_down, 1'b0)
    issue(c_act, 2'h3, 14'h7, 4'h0, 32'h0, 1'b1);
    idle(2, 1'b1);
    issue(c_rd, 2'h3, 14'h0, 4'h0, 32'h0, 1'b1);
    idle(1, 1'b1);
    idle(3, 1'b0);
    #1 `CHK(suspended, 1'b1)
    idle(8, 1'b1);
    #1 `CHK(suspended, 1'b0)
    // clock enable falls with a row still open: active power-down
    idle(3, 1'b0);
    #1 `CHK(powered_down, 1'b1)
    idle(3, 1'b1);
    #1 `CHK(powered_down, 1'b0)
  endtask : t_power
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_banks();
    t_burst();
    t_power();
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : sdram_core_interface_tb_top
`default_nettype wire
